// [design/bus_shared_gpio_ports_e_f.sv]
// Two shared general-purpose ports with their register file.
`include "gpio_ef_map.svh"

module bus_shared_gpio_ports_e_f
    import gpio_ef_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic boot_ram_exec,
    input wire logic [7:0] e_pin_in,
    output logic [7:0] e_pin_out,
    output logic [7:0] e_pin_oe_n,
    output logic e_schmitt_sel,
    input wire logic [7:0] bus_hi_out,
    input wire logic bus_hi_drive,
    input wire logic demux_bus,
    output logic [7:0] bus_hi_in,
    input wire logic [7:0] f_pin_in,
    output logic [7:0] f_pin_out,
    output logic [7:0] f_pin_oe_n,
    output logic [2:0] f_analog_en,
    input wire logic io_chip_select_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b_n,
    input wire logic addr16,
    input wire logic upper_byte_select_n,
    input wire logic lower_byte_select_n
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [7:0] e_s1_q, e_s2_q, f_s1_q, f_s2_q;
    logic [7:0] e_s1_d, e_s2_d, f_s1_d, f_s2_d;

    always_comb
    begin
        e_s1_d = e_pin_in;
        e_s2_d = e_s1_q;
        f_s1_d = f_pin_in;
        f_s2_d = f_s1_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            e_s1_q <= 8'h00;
            e_s2_q <= 8'h00;
            f_s1_q <= 8'h00;
            f_s2_q <= 8'h00;
        end
        else
        begin
            e_s1_q <= e_s1_d;
            e_s2_q <= e_s2_d;
            f_s1_q <= f_s1_d;
            f_s2_q <= f_s2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.
    logic [7:0] e_dir_q, e_dir_d, e_lat_q, e_lat_d;
    logic [7:0] f_dir_q, f_dir_d, f_lat_q, f_lat_d;
    logic [7:0] mem_q, mem_d, rng_b_q, rng_b_d, rng_io_q, rng_io_d;
    logic [2:0] an_q, an_d;
    logic [1:0] keys_q, keys_d;
    lock_state_type lock_q, lock_d;
    logic [7:0] rdata_q, rdata_d;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    logic wr_e_lat, wr_f_lat;
    assign wr_e_lat = reg_wr && (hit(reg_addr, `OFS_E_PINS) ||
                                 hit(reg_addr, `OFS_E_LATCH)); // [R4]
    assign wr_f_lat = reg_wr && (hit(reg_addr, `OFS_F_PINS) ||
                                 hit(reg_addr, `OFS_F_LATCH)); // [R4]

    always_comb
    begin
        e_dir_d = e_dir_q;
        e_lat_d = e_lat_q;
        f_dir_d = f_dir_q;
        f_lat_d = f_lat_q;
        mem_d = mem_q;
        rng_b_d = rng_b_q;
        rng_io_d = rng_io_q;
        an_d = an_q;
        keys_d = keys_q;
        lock_d = lock_q;
        if (wr_e_lat)
            e_lat_d = reg_wdata;
        if (wr_f_lat)
            f_lat_d = reg_wdata;
        if (reg_wr)
        begin
            case (reg_addr)
                `OFS_E_DIR: e_dir_d = reg_wdata;
                `OFS_F_DIR: f_dir_d = reg_wdata;
                `OFS_MEM_CTRL: mem_d = reg_wdata & `MEM_CTRL_MASK;
                `OFS_RANGE_IO: rng_io_d = reg_wdata;
                `OFS_ANALOG_SEL: an_d = reg_wdata[2:0];
                default: ;
            endcase
        end
        case (lock_q)
            LOCK_CLOSED:
            begin
                if (reg_wr && hit(reg_addr, `OFS_LOCK_CTRL))
                begin
                    keys_d = keys_q | {reg_wdata[`BIT_KEY_HIGH],
                                       reg_wdata[`BIT_KEY_LOW]};
                    if (keys_d == 2'h3)
                        lock_d = LOCK_OPEN; // [R17]
                end
            end
            LOCK_OPEN:
            begin
                if (reg_wr && hit(reg_addr, `OFS_RANGE_B))
                begin
                    rng_b_d = reg_wdata; // [R17]
                    keys_d = 2'h0;
                    lock_d = LOCK_CLOSED;
                end
            end
            default:
            begin
                keys_d = 2'h0;
                lock_d = LOCK_CLOSED;
            end
        endcase
    end

    always_comb
    begin
        case (reg_addr)
            `OFS_E_DIR: rdata_d = e_dir_q;
            `OFS_E_PINS: rdata_d = e_s2_q; // [R4]
            `OFS_E_LATCH: rdata_d = e_lat_q; // [R3]
            `OFS_F_DIR: rdata_d = f_dir_q;
            `OFS_F_PINS: rdata_d = f_s2_q; // [R4]
            `OFS_F_LATCH: rdata_d = f_lat_q; // [R3]
            `OFS_MEM_CTRL: rdata_d = mem_q;
            `OFS_LOCK_CTRL: rdata_d = {6'h00, keys_q};
            `OFS_RANGE_B: rdata_d = rng_b_q;
            `OFS_RANGE_IO: rdata_d = rng_io_q;
            `OFS_ANALOG_SEL: rdata_d = {5'h00, an_q};
            default: rdata_d = 8'h00;
        endcase
        if (!reg_rd)
            rdata_d = 8'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            e_dir_q <= `RST_DIR;
            e_lat_q <= `RST_LATCH;
            f_dir_q <= `RST_DIR;
            f_lat_q <= `RST_LATCH;
            mem_q <= `RST_MEM_CTRL; // [R7]
            rng_b_q <= 8'h00;
            rng_io_q <= 8'h00;
            an_q <= `RST_ANALOG_SEL; // [R10]
            keys_q <= 2'h0;
            lock_q <= LOCK_CLOSED;
            rdata_q <= 8'h00;
        end
        else
        begin
            e_dir_q <= e_dir_d;
            e_lat_q <= e_lat_d;
            f_dir_q <= f_dir_d;
            f_lat_q <= f_lat_d;
            mem_q <= mem_d;
            rng_b_q <= rng_b_d;
            rng_io_q <= rng_io_d;
            an_q <= an_d;
            keys_q <= keys_d;
            lock_q <= lock_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin ownership and drivers, all registered.
    logic bus_dis;
    logic [7:0] f_alt, f_alt_out, f_alt_oe_n;
    logic [7:0] e_out_d, e_oe_d, f_out_d, f_oe_d, bus_in_d;
    logic [7:0] e_out_q, e_oe_q, f_out_q, f_oe_q, bus_in_q;
    logic [2:0] an_en_q;
    logic schmitt_q;

    assign bus_dis = mem_q[`BIT_BUS_DISABLE]; // [R5]

    always_comb
    begin
        f_alt = 8'h00;
        f_alt[2:0] = an_q; // [R10]
        f_alt[3] = (rng_io_q != 8'h00); // [R11]
        f_alt[5] = !bus_dis; // [R11] [R16]
        if (LARGE_VARIANT)
            f_alt[4] = (rng_b_q != 8'h00); // [R12] [R16]
        else
            f_alt[4] = !(bus_dis && boot_ram_exec); // [R12] [R14]
        f_alt[7:6] = {2{mem_q[1:0] == `WIDTH_MODE_16}}; // [R15]
        f_alt_out = {upper_byte_select_n, lower_byte_select_n,
                     chip_select_a_n,
                     (LARGE_VARIANT ? chip_select_b_n : addr16),
                     io_chip_select_n, 3'h0};
        f_alt_oe_n = {5'h00, 3'h7};
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            always_comb
            begin
                if (!bus_dis)
                begin
                    e_out_d[i] = bus_hi_out[i]; // [R6] [R9]
                    e_oe_d[i] = !bus_hi_drive;
                end
                else
                begin
                    e_out_d[i] = e_lat_q[i]; // [R2]
                    e_oe_d[i] = e_dir_q[i]; // [R1]
                end
                if (f_alt[i])
                begin
                    f_out_d[i] = f_alt_out[i]; // [R18]
                    f_oe_d[i] = f_alt_oe_n[i];
                end
                else
                begin
                    f_out_d[i] = f_lat_q[i]; // [R2]
                    f_oe_d[i] = f_dir_q[i]; // [R1]
                end
                bus_in_d[i] = bus_dis ? 1'b0 : e_s2_q[i];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            e_out_q <= 8'h00;
            e_oe_q <= 8'hff;
            f_out_q <= 8'h00;
            f_oe_q <= 8'hff;
            bus_in_q <= 8'h00;
            an_en_q <= `RST_ANALOG_SEL;
            schmitt_q <= 1'b0;
        end
        else
        begin
            e_out_q <= e_out_d; // [R19]
            e_oe_q <= e_oe_d;
            f_out_q <= f_out_d;
            f_oe_q <= f_oe_d;
            bus_in_q <= bus_in_d;
            an_en_q <= an_q;
            schmitt_q <= bus_dis; // [R8]
        end
    end

    assign e_pin_out = e_out_q;
    assign e_pin_oe_n = e_oe_q;
    assign f_pin_out = f_out_q;
    assign f_pin_oe_n = f_oe_q;
    assign f_analog_en = an_en_q;
    assign e_schmitt_sel = schmitt_q;
    assign bus_hi_in = bus_in_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    // A write to the protected range while the combination lock is open.
    sequence s_open_write;
        reg_wr && reg_addr == `OFS_RANGE_B && lock_q == LOCK_OPEN;
    endsequence

    sequence s_closed;
        lock_q == LOCK_CLOSED && keys_q == 2'h0;
    endsequence

    property p_dir_in;
        @(posedge ref_clk) disable iff (rst)
        bus_dis && !$past(rst) |=> e_oe_q == $past(e_dir_q);
    endproperty
    a_dir_in: assert property (p_dir_in) // [R1]
        else $error("fifth port enable does not follow direction");

    property p_drive;
        @(posedge ref_clk) disable iff (rst)
        bus_dis && e_dir_q[0] == 1'b0 |=> e_pin_out[0] == $past(e_lat_q[0]);
    endproperty
    a_drive: assert property (p_drive) // [R2]
        else $error("fifth port pin not driven from latch");

    property p_latch_rd;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `OFS_F_LATCH |=> reg_rdata == $past(f_lat_q);
    endproperty
    a_latch_rd: assert property (p_latch_rd) // [R3]
        else $error("latch read wrong");

    property p_pin_rd;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `OFS_E_PINS |=> reg_rdata == $past(e_s2_q);
    endproperty
    a_pin_rd: assert property (p_pin_rd) // [R4]
        else $error("pin read wrong");

    property p_pin_wr;
        @(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `OFS_E_PINS |=> e_lat_q == $past(reg_wdata);
    endproperty
    a_pin_wr: assert property (p_pin_wr) // [R4]
        else $error("pin write did not load latch");

    property p_bus_own;
        @(posedge ref_clk) disable iff (rst)
        !bus_dis ##1 !bus_dis |-> e_pin_out == $past(bus_hi_out);
    endproperty
    a_bus_own: assert property (p_bus_own) // [R5]
        else $error("bus does not own fifth port");

    property p_bytesel;
        @(posedge ref_clk) disable iff (rst)
        mem_q[1:0] != `WIDTH_MODE_16
        |=> f_pin_oe_n[7:6] == $past(f_dir_q[7:6]);
    endproperty
    a_bytesel: assert property (p_bytesel) // [R15]
        else $error("byte selects not released");

    property p_lock;
        @(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `OFS_RANGE_B && lock_q == LOCK_CLOSED
        |=> $stable(rng_b_q);
    endproperty
    a_lock: assert property (p_lock) // [R17]
        else $error("protected range written while locked");

    property p_relock;
        @(posedge ref_clk) disable iff (rst)
        s_open_write |=> s_closed;
    endproperty
    a_relock: assert property (p_relock) // [R17]
        else $error("lock did not close");

    property p_analog_off;
        @(posedge ref_clk) disable iff (rst)
        an_q != 3'h0
        |=> (f_pin_oe_n[2:0] & $past(an_q)) == $past(an_q);
    endproperty
    a_analog_off: assert property (p_analog_off) // [R10]
        else $error("analog pin still driven");

    property p_io_select;
        @(posedge ref_clk) disable iff (rst)
        rng_io_q != 8'h00
        |=> f_pin_out[3] == $past(io_chip_select_n) && !f_pin_oe_n[3];
    endproperty
    a_io_select: assert property (p_io_select) // [R11]
        else $error("io chip select does not own its pin");

    property p_schmitt;
        @(posedge ref_clk) disable iff (rst)
        1'h1 |=> e_schmitt_sel == $past(bus_dis);
    endproperty
    a_schmitt: assert property (p_schmitt) // [R8]
        else $error("input buffer select does not follow bus mode");

endmodule

// [design/gpio_ef_map.svh]
// Register offsets, field positions, reset values, a write mask and the 16-bit width code.
//
// Behaviour
// R1: Direction bit one tristates the pin driver.
// R2: Direction bit zero drives pin from latch.
// R3: Latch register read returns latch, not pins.
// R4: Pin register reads pins, write loads latch.
// R5: Fifth port is I/O only with bus disabled.
// R6: Bus mode carries upper address/data byte.
// R7: Fifth port defaults to bus after reset.
// R8: Schmitt input in I/O, TTL in bus.
// R9: Multiplexed in 16-bit, address-only 8-bit large.
// R10: Sixth bits 0-2 analog, default analog.
// R11: Sixth bits 3,5 carry I/O and chip select.
// R12: Sixth bit 4 chip select b or A16.
// R13: Software clears range registers for I/O use.
// R14: Small variant bit 4 needs disable and boot RAM.
// R15: Bits 6,7 byte selects only when width 01.
// R16: Sixth bits 3-7 default to bus signals; the code starts only bit 5 (and bit 4 on the small variant) as a bus pin.
// R17: Range register b write needs both lock keys.
// R18: Alternate functions override without touching registers.
// R19: Register writes reach pins next clock edge.
`ifndef GPIO_EF_MAP_SVH
`define GPIO_EF_MAP_SVH

`define OFS_E_DIR 4'h0
`define OFS_E_PINS 4'h1
`define OFS_E_LATCH 4'h2
`define OFS_F_DIR 4'h3
`define OFS_F_PINS 4'h4
`define OFS_F_LATCH 4'h5
`define OFS_MEM_CTRL 4'h6
`define OFS_LOCK_CTRL 4'h7
`define OFS_RANGE_B 4'h8
`define OFS_RANGE_IO 4'h9
`define OFS_ANALOG_SEL 4'ha

`define RST_DIR 8'hff
`define RST_LATCH 8'h00
`define RST_MEM_CTRL 8'h00
`define RST_ANALOG_SEL 3'h7
`define MEM_CTRL_MASK 8'hf3
`define BIT_BUS_DISABLE 7
`define BIT_KEY_HIGH 1
`define BIT_KEY_LOW 0
`define WIDTH_MODE_16 2'h1

`endif

// [design/gpio_ef_pkg.sv]
// Types shared by the port block.
package gpio_ef_pkg;
    typedef enum logic [1:0] {
        LOCK_CLOSED = 2'b01,
        LOCK_OPEN = 2'b10
    } lock_state_type;
endpackage

// [sim/ext_pin_device.sv]
// Far-side device that drives a port's pads whenever the block releases them.
module ext_pin_device
(
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] drive,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pad shows the block's value while enabled, else this device's value.
    assign pin_in = (pin_out & ~pin_oe_n) | (drive & pin_oe_n);
endmodule

// [sim/testbench.sv]
// Self-checking bench for the shared fifth and sixth ports.
`include "gpio_ef_map.svh"
module testbench
    import gpio_ef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, reg_wr, reg_rd, boot_ram_exec, bus_hi_drive;
    logic demux_bus, e_schmitt_sel, io_chip_select_n, chip_select_a_n;
    logic chip_select_b_n, addr16, upper_byte_select_n, lower_byte_select_n;
    logic [3:0] reg_addr;
    logic [2:0] f_analog_en;
    logic [7:0] reg_wdata, reg_rdata, e_pin_in, e_pin_out, e_pin_oe_n;
    logic [7:0] bus_hi_out, bus_hi_in, f_pin_in, f_pin_out, f_pin_oe_n;
    logic [7:0] e_ext, f_ext, d, l;
    logic [7:0] exp_q[$];
    logic rd_d;
    int bad_count, checks_done, cycles, seed;

    bus_shared_gpio_ports_e_f #(.LARGE_VARIANT(1'h1))
    i_bus_shared_gpio_ports_e_f
    (
        .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .boot_ram_exec, .e_pin_in, .e_pin_out, .e_pin_oe_n, .e_schmitt_sel,
        .bus_hi_out, .bus_hi_drive, .demux_bus, .bus_hi_in, .f_pin_in,
        .f_pin_out, .f_pin_oe_n, .f_analog_en, .io_chip_select_n,
        .chip_select_a_n, .chip_select_b_n, .addr16, .upper_byte_select_n,
        .lower_byte_select_n
    );
    ext_pin_device i_ext_pin_device_e
    (
        .pin_out(e_pin_out), .pin_oe_n(e_pin_oe_n), .drive(e_ext),
        .pin_in(e_pin_in)
    );
    ext_pin_device i_ext_pin_device_f
    (
        .pin_out(f_pin_out), .pin_oe_n(f_pin_oe_n), .drive(f_ext),
        .pin_in(f_pin_in)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One register cycle; a read also queues the value it should return.
    task automatic bus(input bit w, input logic [3:0] a, input logic [7:0] v);
        if (!w)
            exp_q.push_back(v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    always @(posedge ref_clk)
    begin
        rd_d <= reg_rd;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end

    always @(negedge ref_clk)
        if (rd_d === 1'h1)
            check("reg_rdata", reg_rdata, exp_q.pop_front());

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 52;
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, rd_d} = '0;
        cycles = 0;
        {boot_ram_exec, bus_hi_drive, demux_bus, bus_hi_out} = '0;
        {io_chip_select_n, chip_select_a_n, chip_select_b_n} = 3'h7;
        {addr16, upper_byte_select_n, lower_byte_select_n} = 3'h7;
        {e_ext, f_ext, bad_count, checks_done} = '0;
        rst = 1'h1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        tick(1);
        check("schmitt", {7'h0, e_schmitt_sel}, 8'h00);
        check("analog_en", {5'h0, f_analog_en}, 8'h07);
        bus(0, `OFS_E_DIR, 8'hff);
        bus(0, `OFS_MEM_CTRL, 8'h00);
        bus(0, `OFS_F_DIR, 8'hff);
        bus(0, `OFS_ANALOG_SEL, 8'h07);
        bus(0, `OFS_RANGE_B, 8'h00);
        bus(1, 4'hc, 8'h5a);
        bus(0, 4'hc, 8'h00);
        // Bus mode: register writes must not reach the fifth port's pads.
        l = 8'($random(seed));
        bus(1, `OFS_E_LATCH, l);
        bus(1, `OFS_E_DIR, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge ref_clk);
            bus_hi_drive <= 1'h1;
            demux_bus <= i[0];
            bus_hi_out <= 8'($random(seed));
            tick(2);
            check("e_pin_out", e_pin_out, bus_hi_out);
            check("e_pin_oe_n", e_pin_oe_n, 8'h00);
        end
        @(posedge ref_clk);
        bus_hi_drive <= 1'h0;
        e_ext <= 8'($random(seed));
        tick(5);
        check("e_pin_oe_n", e_pin_oe_n, 8'hff);
        check("bus_hi_in", bus_hi_in, e_ext);
        bus(1, `OFS_MEM_CTRL, 8'hff);
        bus(0, `OFS_MEM_CTRL, 8'hf3);
        bus(0, `OFS_E_LATCH, l);
        bus(0, `OFS_E_DIR, 8'h00);
        tick(2);
        check("schmitt", {7'h0, e_schmitt_sel}, 8'h01);
        check("bus_hi_in", bus_hi_in, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($random(seed));
            l = 8'($random(seed));
            @(posedge ref_clk);
            e_ext <= 8'($random(seed));
            bus(1, `OFS_E_DIR, d);
            bus(1, `OFS_E_PINS, l);
            tick(2);
            check("e_pin_oe_n", e_pin_oe_n, d);
            check("e_pin_out", e_pin_out & ~d, l & ~d);
            bus(0, `OFS_E_LATCH, l);
            tick(3);
            bus(0, `OFS_E_PINS, (l & ~d) | (e_ext & d));
        end
        // Sixth port with every bus-side function enabled.
        @(posedge ref_clk);
        {upper_byte_select_n, lower_byte_select_n} <= 2'h1;
        {chip_select_a_n, chip_select_b_n, io_chip_select_n} <= 3'h3;
        addr16 <= 1'h0;
        bus(1, `OFS_F_DIR, 8'h00);
        bus(1, `OFS_F_LATCH, 8'ha5);
        bus(1, `OFS_ANALOG_SEL, 8'h00);
        bus(1, `OFS_MEM_CTRL, 8'h01);
        bus(1, `OFS_RANGE_IO, 8'h01);
        bus(1, `OFS_RANGE_B, 8'h20);
        bus(0, `OFS_RANGE_B, 8'h00);
        bus(1, `OFS_LOCK_CTRL, 8'h02);
        bus(1, `OFS_LOCK_CTRL, 8'h01);
        bus(1, `OFS_RANGE_B, 8'h20);
        bus(1, `OFS_RANGE_B, 8'h40);
        bus(0, `OFS_RANGE_B, 8'h20);
        tick(2);
        check("analog_en", {5'h0, f_analog_en}, 8'h00);
        check("f_pin_out", f_pin_out, 8'h5d);
        // Ranges cleared and width not 01, so only bit 5 stays a bus pin.
        bus(1, `OFS_LOCK_CTRL, 8'h03);
        bus(1, `OFS_RANGE_B, 8'h00);
        bus(1, `OFS_RANGE_IO, 8'h00);
        for (int w = 0; w < 4; w++)
        begin
            if (w == 1)
                continue;
            bus(1, `OFS_MEM_CTRL, w[7:0]);
            tick(2);
            check("f_pin_out", f_pin_out, 8'h85);
        end
        bus(1, `OFS_MEM_CTRL, 8'h80);
        tick(2);
        check("f_pin_out", f_pin_out, 8'ha5);
        @(posedge ref_clk);
        f_ext <= 8'($random(seed));
        bus(1, `OFS_F_DIR, 8'hff);
        tick(5);
        check("f_pin_oe_n", f_pin_oe_n, 8'hff);
        bus(0, `OFS_F_PINS, f_ext);
        bus(0, `OFS_F_LATCH, 8'ha5);
        tick(3);
        summarize();
    end
endmodule
